// ---- hw/dsr_core.sv ----
// Idle mode, analog reference scaling, monitor outputs and aux input.
// Assumes ADC codes, speeds and load come from logic on sys_clk;
// only the aux contact is asynchronous.
//
// The address map and the APB register port were left to the implementer.
module dsr_core #(
	parameter int unsigned TICK_CYCLES = dsr_pkg::TICK_CYCLES
) (
	input  wire logic        sys_clk,
	input  wire logic        reset_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	input  wire logic [15:0] cmd_speed,
	input  wire logic        run_active,
	input  wire logic        start_cmd,
	input  wire logic [15:0] feedback,
	input  wire logic [11:0] voltage_ref_input,
	input  wire logic [11:0] current_ref_input,
	input  wire logic [15:0] output_freq,
	input  wire logic [15:0] drive_load,
	input  wire logic        aux_contact_a,
	output logic             doze_active,
	output logic             doze_display,
	output logic             doze_relay,
	output logic [15:0]      speed_target,
	output logic [15:0]      ref_freq,
	output logic [1:0]       ref_source,
	output logic             local_mode,
	output logic             terminal_cmd_enable,
	output logic             setpoint_decrease,
	output logic [11:0]      freq_analog_output,
	output logic [11:0]      load_analog_output
);
	import dsr_pkg::*;

	typedef enum logic [1:0] {
		DSR_AWAKE = 2'b01,
		DSR_DOZE  = 2'b10
	} dsr_doze_type;

	typedef enum logic [2:0] {
		DSR_MON_LOAD  = 3'b001,
		DSR_MON_DIV   = 3'b010,
		DSR_MON_STORE = 3'b100
	} dsr_mon_type;

	typedef struct packed {
		logic          pready;
		logic          pslverr;
		logic [31:0]   prdata;
		logic [15:0]   doze_speed_limit;
		logic [15:0]   doze_hold_time;
		logic [15:0]   wake_feedback_band;
		logic [15:0]   setpoint;
		logic          reverse_acting;
		logic [15:0]   ref_low_point_freq;
		logic [15:0]   ref_high_point_freq;
		logic [2:0]    analog_input_smoothing;
		logic [15:0]   preset_speed_one;
		logic [1:0]    freq_monitor_range;
		logic [15:0]   freq_monitor_full_scale;
		logic [1:0]    load_monitor_range;
		logic [15:0]   load_monitor_full_scale;
		logic [15:0]   load_scale_factor;
		logic [2:0]    aux_input_a_function;
		logic [1:0]    ctrl_source;
		logic          relay_doze_sel;
		logic [2:0]    aux_sync;
		logic          aux_level;
		logic [23:0]   tick_cnt;
		logic          tick;
		dsr_doze_type  doze;
		logic [15:0]   remain;
		logic          doze_display;
		logic          doze_relay;
		logic [15:0]   speed_target;
		logic [19:0]   filt_v;
		logic [19:0]   filt_c;
		logic [15:0]   ref_freq;
		logic [1:0]    ref_source;
		logic          local_mode;
		logic          terminal_cmd_enable;
		logic          setpoint_decrease;
		dsr_mon_type   mon;
		logic          mon_chan;
		logic          mon_sat;
		logic [47:0]   rem;
		logic [47:0]   den;
		logic [11:0]   quot;
		logic [3:0]    bit_idx;
		logic [11:0]   fmon_code;
		logic [11:0]   lmon_code;
	} dsr_state_type;

	dsr_state_type state;
	dsr_state_type next_state;

	logic        below;
	logic        speed_wake;
	logic        band_wake;
	logic        bus_write;
	logic [31:0] rd_word;
	logic        rd_hit;
	logic [11:0] norm_v;
	logic [11:0] norm_c;
	logic [12:0] cur_lift;
	logic [13:0] cur_wide;
	logic [11:0] norm_sel;
	logic signed [16:0] span;
	logic signed [30:0] span_prod;
	logic [15:0] scaled;
	logic [31:0] load_scaled;
	logic [47:0] trial;
	logic [23:0] live_prod;
	logic [11:0] range_code;
	logic [1:0]  range_sel;
	logic signed [20:0] diff_v;
	logic signed [20:0] diff_c;

	always_comb begin
		// Comparisons in the same 0.1 Hz units as the command
		below      = cmd_speed < state.doze_speed_limit;
		speed_wake = {1'b0, cmd_speed} >=
			({1'b0, state.doze_speed_limit} + {1'b0, WAKE_MARGIN});
		if (state.wake_feedback_band == 16'h0000) begin
			band_wake = 1'b0;
		end else if (state.reverse_acting) begin
			band_wake = {1'b0, feedback} >
				({1'b0, state.setpoint} + {1'b0, state.wake_feedback_band});
		end else begin
			band_wake = ({1'b0, feedback} + {1'b0, state.wake_feedback_band}) <
				{1'b0, state.setpoint};
		end
	end

	always_comb begin
		rd_hit  = 1'b1;
		rd_word = 32'h0000_0000;
		case (paddr)
			OFS_DOZE_LIMIT: rd_word[15:0] = state.doze_speed_limit;
			OFS_DOZE_HOLD:  rd_word[15:0] = state.doze_hold_time;
			OFS_WAKE_BAND:  rd_word[15:0] = state.wake_feedback_band;
			OFS_LOOP: begin
				rd_word[15:0]       = state.setpoint;
				rd_word[POS_REVERSE] = state.reverse_acting;
			end
			OFS_REF_LOW:    rd_word[15:0] = state.ref_low_point_freq;
			OFS_REF_HIGH:   rd_word[15:0] = state.ref_high_point_freq;
			OFS_SMOOTH:     rd_word[2:0]  = state.analog_input_smoothing;
			OFS_PRESET_ONE: rd_word[15:0] = state.preset_speed_one;
			OFS_FMON: begin
				rd_word[15:0] = state.freq_monitor_full_scale;
				rd_word[POS_RANGE +: 2] = state.freq_monitor_range;
			end
			OFS_LMON: begin
				rd_word[15:0] = state.load_monitor_full_scale;
				rd_word[POS_RANGE +: 2] = state.load_monitor_range;
			end
			OFS_LOAD_SCALE: rd_word[15:0] = state.load_scale_factor;
			OFS_AUX: begin
				rd_word[2:0] = state.aux_input_a_function;
				rd_word[POS_CTRL_SRC +: 2] = state.ctrl_source;
				rd_word[POS_RELAY_DOZE] = state.relay_doze_sel;
			end
			OFS_STATUS: rd_word[5:0] = {state.ref_source, state.aux_level,
				state.local_mode, state.doze_display,
				state.doze == DSR_DOZE};
			OFS_REF_FREQ:   rd_word[15:0] = state.ref_freq;
			OFS_MON_CODES:  rd_word[27:0] = {state.lmon_code, 4'h0,
				state.fmon_code};
			default:        rd_hit = 1'b0;
		endcase
	end

	always_comb begin
		// Current input: lift the 4 mA live zero and stretch by 5/4
		norm_v   = state.filt_v[19:8];
		cur_lift = (state.filt_c[19:8] > CODE_LIVE_ZERO) ?
			{1'b0, state.filt_c[19:8] - CODE_LIVE_ZERO} : 13'h0000;
		cur_wide = {1'b0, cur_lift} + {3'h0, cur_lift[12:2]};
		norm_c   = (cur_wide > {2'h0, CODE_FULL}) ? CODE_FULL :
			cur_wide[11:0];
		norm_sel = (state.aux_level &&
			state.aux_input_a_function == DSR_AUX_CURR_REF) ? norm_c : norm_v;
		// Signed span makes the inverse mapping fall out naturally
		span      = $signed({1'b0, state.ref_high_point_freq}) -
			$signed({1'b0, state.ref_low_point_freq});
		span_prod = 31'(span * $signed({1'b0, norm_sel}));
		if (norm_sel == CODE_FULL) begin
			scaled = state.ref_high_point_freq;
		end else begin
			scaled = 16'($signed({1'b0, state.ref_low_point_freq}) +
				(span_prod >>> 12));
		end
		diff_v = $signed({1'b0, voltage_ref_input, 8'h00}) -
			$signed({1'b0, state.filt_v});
		diff_c = $signed({1'b0, current_ref_input, 8'h00}) -
			$signed({1'b0, state.filt_c});
	end

	always_comb begin
		load_scaled = drive_load * state.load_scale_factor;
		trial       = state.den << state.bit_idx;
		range_sel   = state.mon_chan ? state.load_monitor_range :
			state.freq_monitor_range;
		live_prod   = state.quot * (CODE_FULL - CODE_LIVE_ZERO);
		case (range_sel)
			DSR_RANGE_FULL: range_code = state.quot;
			DSR_RANGE_LIVE: range_code = CODE_LIVE_ZERO +
				live_prod[23:12];
			default:        range_code = 12'h000;
		endcase
	end

	always_comb begin
		next_state = state;
		bus_write  = psel && penable && pwrite && state.pready;

		// Zero wait state slave: answer in the access cycle
		next_state.pready = psel && !penable;
		if (psel && !penable) begin
			next_state.pslverr = !rd_hit;
			next_state.prdata  = pwrite ? 32'h0000_0000 : rd_word;
		end
		if (bus_write) begin
			case (paddr)
				OFS_DOZE_LIMIT: next_state.doze_speed_limit = pwdata[15:0];
				OFS_DOZE_HOLD:  next_state.doze_hold_time = pwdata[15:0];
				OFS_WAKE_BAND:  next_state.wake_feedback_band = pwdata[15:0];
				OFS_LOOP: begin
					next_state.setpoint       = pwdata[15:0];
					next_state.reverse_acting = pwdata[POS_REVERSE];
				end
				OFS_REF_LOW:    next_state.ref_low_point_freq = pwdata[15:0];
				OFS_REF_HIGH:   next_state.ref_high_point_freq = pwdata[15:0];
				OFS_SMOOTH:     next_state.analog_input_smoothing = pwdata[2:0];
				OFS_PRESET_ONE: next_state.preset_speed_one = pwdata[15:0];
				OFS_FMON: begin
					next_state.freq_monitor_full_scale = pwdata[15:0];
					next_state.freq_monitor_range = pwdata[POS_RANGE +: 2];
				end
				OFS_LMON: begin
					next_state.load_monitor_full_scale = pwdata[15:0];
					next_state.load_monitor_range = pwdata[POS_RANGE +: 2];
				end
				OFS_LOAD_SCALE: next_state.load_scale_factor = pwdata[15:0];
				OFS_AUX: begin
					next_state.aux_input_a_function = pwdata[2:0];
					next_state.ctrl_source = pwdata[POS_CTRL_SRC +: 2];
					next_state.relay_doze_sel = pwdata[POS_RELAY_DOZE];
				end
				default: ;
			endcase
		end

		// Contact level accepted only once the last two stages agree
		next_state.aux_sync = {state.aux_sync[1:0], aux_contact_a};
		if (state.aux_sync[1] == state.aux_sync[2]) begin
			next_state.aux_level = state.aux_sync[2];
		end

		next_state.tick = 1'b0;
		if (state.tick_cnt >= 24'(TICK_CYCLES - 1)) begin
			next_state.tick_cnt = 24'h000000;
			next_state.tick     = 1'b1;
		end else begin
			next_state.tick_cnt = state.tick_cnt + 24'h000001;
		end

		case (state.doze)
			DSR_AWAKE: begin
				if (!below || !run_active) begin
					next_state.remain = state.doze_hold_time;
				end else if (state.tick) begin
					if (state.remain == 16'h0000) begin
						next_state.doze = DSR_DOZE;
					end else begin
						next_state.remain = state.remain - 16'h0001;
					end
				end
				if (start_cmd && !run_active && below) begin
					next_state.doze = DSR_DOZE;
				end
			end
			DSR_DOZE: begin
				if (!run_active || speed_wake || band_wake) begin
					next_state.doze   = DSR_AWAKE;
					next_state.remain = state.doze_hold_time;
				end
			end
			default: next_state.doze = DSR_AWAKE;
		endcase
		next_state.doze_display = state.doze == DSR_DOZE;
		next_state.doze_relay   = state.relay_doze_sel &&
			state.doze == DSR_DOZE;
		// Motor held at zero while idle; ramp is outside this block
		next_state.speed_target = (state.doze == DSR_DOZE) ?
			16'h0000 : cmd_speed;

		// First-order smoothing, heavier for larger settings
		if (state.tick) begin
			next_state.filt_v = 20'($signed({1'b0, state.filt_v}) +
				(diff_v >>> state.analog_input_smoothing));
			next_state.filt_c = 20'($signed({1'b0, state.filt_c}) +
				(diff_c >>> state.analog_input_smoothing));
		end

		next_state.ref_source = 2'(DSR_AUX_VOLT_REF);
		next_state.ref_freq   = scaled;
		if (state.aux_level) begin
			case (state.aux_input_a_function)
				DSR_AUX_CURR_REF: next_state.ref_source =
					2'(DSR_AUX_CURR_REF);
				DSR_AUX_PRESET: begin
					next_state.ref_source = 2'(DSR_AUX_PRESET);
					next_state.ref_freq   = state.preset_speed_one;
				end
				default: ;
			endcase
		end

		case (state.ctrl_source)
			DSR_SRC_LOCAL:  next_state.local_mode = 1'b1;
			DSR_SRC_BOTH:   next_state.local_mode = state.aux_level &&
				state.aux_input_a_function == DSR_AUX_LOCAL;
			default:        next_state.local_mode = 1'b0;
		endcase
		next_state.terminal_cmd_enable = !next_state.local_mode;
		next_state.setpoint_decrease = state.aux_level &&
			state.aux_input_a_function == DSR_AUX_DECREASE;

		// One shared divider serves both monitors in turn
		case (state.mon)
			DSR_MON_LOAD: begin
				next_state.quot    = 12'h000;
				next_state.bit_idx = 4'hb;
				if (!state.mon_chan) begin
					next_state.rem = 48'(output_freq) * 48'(CODE_FULL);
					next_state.den = {32'h0, state.freq_monitor_full_scale};
					next_state.mon_sat = output_freq >=
						state.freq_monitor_full_scale;
				end else begin
					next_state.rem = 48'(load_scaled) * 48'(CODE_FULL);
					next_state.den = 48'(state.load_monitor_full_scale *
						PERCENT_SCALE);
					next_state.mon_sat = 48'(load_scaled) >=
						48'(state.load_monitor_full_scale *
						PERCENT_SCALE);
				end
				next_state.mon = DSR_MON_DIV;
			end
			DSR_MON_DIV: begin
				if (state.rem >= trial) begin
					next_state.rem  = state.rem - trial;
					next_state.quot[state.bit_idx] = 1'b1;
				end
				if (state.bit_idx == 4'h0) begin
					next_state.mon = DSR_MON_STORE;
				end else begin
					next_state.bit_idx = state.bit_idx - 4'h1;
				end
			end
			DSR_MON_STORE: begin
				if (state.mon_sat) begin
					next_state.quot = CODE_FULL;
				end
				next_state.mon = DSR_MON_DIV;
				if (!state.mon_sat) begin
					if (state.mon_chan) begin
						next_state.lmon_code = range_code;
					end else begin
						next_state.fmon_code = range_code;
					end
					next_state.mon_chan = !state.mon_chan;
					next_state.mon      = DSR_MON_LOAD;
				end else begin
					next_state.mon_sat = 1'b0;
					next_state.bit_idx = 4'h0;
					next_state.rem     = 48'h0;
				end
			end
			default: next_state.mon = DSR_MON_LOAD;
		endcase
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= '0;
			state.doze_hold_time <= RST_DOZE_HOLD;
			state.remain <= RST_DOZE_HOLD;
			state.ref_high_point_freq <= RST_REF_HIGH;
			state.freq_monitor_full_scale <= RST_FULL_SCALE;
			state.load_monitor_full_scale <= RST_LOAD_FS;
			state.load_scale_factor <= RST_LOAD_SCALE;
			state.ctrl_source <= DSR_SRC_REMOTE;
			state.terminal_cmd_enable <= 1'b1;
			state.doze <= DSR_AWAKE;
			state.mon <= DSR_MON_LOAD;
		end else begin
			state <= next_state;
		end
	end

	assign pready              = state.pready;
	assign prdata              = state.prdata;
	assign pslverr             = state.pslverr;
	// One-hot idle bit, so the output is a flop and not a compare
	assign doze_active         = state.doze[1];
	assign doze_display        = state.doze_display;
	assign doze_relay          = state.doze_relay;
	assign speed_target        = state.speed_target;
	assign ref_freq            = state.ref_freq;
	assign ref_source          = state.ref_source;
	assign local_mode          = state.local_mode;
	assign terminal_cmd_enable = state.terminal_cmd_enable;
	assign setpoint_decrease   = state.setpoint_decrease;
	assign freq_analog_output  = state.fmon_code;
	assign load_analog_output  = state.lmon_code;

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	a_doze_hold_entry: assert property (
		state.doze == DSR_AWAKE && run_active && below && state.tick &&
		state.remain == 16'h0000 |=> doze_active ##1 speed_target == 16'h0000)
		else $error("idle not entered after hold expiry");
	a_wake_speed: assert property (
		doze_active && run_active && speed_wake |=> !doze_active)
		else $error("idle kept with speed above limit plus margin");
	a_idle_display: assert property (
		$rose(doze_active) |=> doze_display)
		else $error("idle indication missing");
	a_hold_reload: assert property (
		state.doze == DSR_AWAKE && !below && !start_cmd |=>
		!doze_active && state.remain == $past(state.doze_hold_time))
		else $error("hold timer not reloaded");
	a_start_bypass: assert property (
		state.doze == DSR_AWAKE && start_cmd && !run_active && below
		|=> doze_active)
		else $error("start below limit did not enter idle");
	a_band_wake: assert property (
		doze_active && run_active && state.wake_feedback_band != 0 &&
		!state.reverse_acting && 17'(feedback) +
		17'(state.wake_feedback_band) < 17'(state.setpoint) |=> !doze_active)
		else $error("feedback band did not wake");
	a_band_off: assert property (
		doze_active && run_active && state.wake_feedback_band == 0 &&
		!speed_wake |=> doze_active)
		else $error("woke with band disabled and low speed");
	a_local_both: assert property (
		state.ctrl_source == DSR_SRC_BOTH && state.aux_level &&
		state.aux_input_a_function == DSR_AUX_LOCAL |=>
		local_mode && !terminal_cmd_enable)
		else $error("local select not honoured");
	a_idle_relay: assert property (
		doze_active && state.relay_doze_sel |=> doze_relay)
		else $error("idle relay not energised");
	a_mon_saturate: assert property (
		(state.mon == DSR_MON_STORE && state.mon_sat && !state.mon_chan)
		##2 (state.freq_monitor_range == DSR_RANGE_FULL)
		|=> freq_analog_output == CODE_FULL)
		else $error("frequency monitor did not saturate");
endmodule

// ---- hw/dsr_pkg.sv ----
// Constants shared by the idle-mode, reference scaling and monitor logic.
// Assumes a 25 MHz system clock and an APB master with 32-bit data.
package dsr_pkg;
	localparam int unsigned CLK_PERIOD_NS  = 40;
	localparam int unsigned TICK_PERIOD_NS = 1_000_000;
	localparam int unsigned TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
	// Speeds are held in 0.1 Hz steps
	localparam int unsigned UNITS_PER_HZ   = 10;
	localparam int unsigned WAKE_MARGIN_HZ = 2;
	localparam logic [15:0] WAKE_MARGIN    =
		16'(WAKE_MARGIN_HZ * UNITS_PER_HZ);
	localparam logic [11:0] CODE_FULL      = 12'hfff;
	// 4 mA of 20 mA and 2 V of 10 V are both a fifth of full scale
	localparam logic [11:0] CODE_LIVE_ZERO = 12'h333;
	localparam logic [22:0] PERCENT_SCALE  = 23'h000064;

	localparam logic [7:0] OFS_DOZE_LIMIT  = 8'h00;
	localparam logic [7:0] OFS_DOZE_HOLD   = 8'h04;
	localparam logic [7:0] OFS_WAKE_BAND   = 8'h08;
	localparam logic [7:0] OFS_LOOP        = 8'h0c;
	localparam logic [7:0] OFS_REF_LOW     = 8'h10;
	localparam logic [7:0] OFS_REF_HIGH    = 8'h14;
	localparam logic [7:0] OFS_SMOOTH      = 8'h18;
	localparam logic [7:0] OFS_PRESET_ONE  = 8'h1c;
	localparam logic [7:0] OFS_FMON        = 8'h20;
	localparam logic [7:0] OFS_LMON        = 8'h24;
	localparam logic [7:0] OFS_LOAD_SCALE  = 8'h28;
	localparam logic [7:0] OFS_AUX         = 8'h2c;
	localparam logic [7:0] OFS_STATUS      = 8'h30;
	localparam logic [7:0] OFS_REF_FREQ    = 8'h34;
	localparam logic [7:0] OFS_MON_CODES   = 8'h38;

	// Field positions of the loop, aux and monitor registers
	localparam int unsigned POS_REVERSE    = 16;
	localparam int unsigned POS_CTRL_SRC   = 4;
	localparam int unsigned POS_RELAY_DOZE = 8;
	localparam int unsigned POS_RANGE      = 16;

	localparam logic [15:0] RST_DOZE_HOLD  = 16'h0000;
	localparam logic [15:0] RST_REF_HIGH   = 16'h0258;
	localparam logic [15:0] RST_FULL_SCALE = 16'h0258;
	localparam logic [15:0] RST_LOAD_FS    = 16'h00c8;
	localparam logic [15:0] RST_LOAD_SCALE = 16'h0064;

	typedef enum logic [2:0] {
		DSR_AUX_NONE     = 3'h0,
		DSR_AUX_VOLT_REF = 3'h1,
		DSR_AUX_CURR_REF = 3'h2,
		DSR_AUX_PRESET   = 3'h3,
		DSR_AUX_LOCAL    = 3'h4,
		DSR_AUX_DECREASE = 3'h5
	} dsr_aux_type;

	typedef enum logic [1:0] {
		DSR_SRC_LOCAL  = 2'h0,
		DSR_SRC_REMOTE = 2'h1,
		DSR_SRC_BOTH   = 2'h2
	} dsr_src_type;

	typedef enum logic [1:0] {
		DSR_RANGE_OFF  = 2'h0,
		DSR_RANGE_FULL = 2'h1,
		DSR_RANGE_LIVE = 2'h2
	} dsr_range_type;
endpackage

// ---- verif/dsr_terminal_model.sv ----
// Terminal strip model: aux contact and analog reference sources.
// Assumes the bench asks for changes right after a rising sys_clk edge.
module dsr_terminal_model (
	input  wire logic        sys_clk,
	input  wire logic        close_a,
	input  wire logic [11:0] volt_code,
	output logic             aux_contact_a = 1'b0,
	output logic [11:0]      voltage_ref_input = 12'h000,
	output logic [11:0]      current_ref_input = 12'h333
);
	timeunit 1ns;
	timeprecision 1ps;
	// Contact closed to common is the only way to activate the function
	always @(posedge sys_clk) begin
		aux_contact_a <= close_a;
		voltage_ref_input <= volt_code;
		// Loop current parked at 4 mA, the live zero of the current input
		current_ref_input <= 12'h333;
	end
endmodule

// ---- verif/drive_sleep_and_reference_scaling_tb_top.sv ----
// Bench for the idle, reference scaling and monitor block.
// Assumes dsr_core with a short tick and the terminal strip model.
module drive_sleep_and_reference_scaling_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import dsr_pkg::*;
	logic sys_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, rd, prdata;
	logic pready, pslverr, err, run_active = 0, start_cmd = 0, close_a = 0;
	logic [15:0] cmd_speed = 0, feedback = 0, output_freq = 0, drive_load = 0;
	logic [11:0] volt_code = 0, vref, cref, fao, lao;
	logic [15:0] speed_target, ref_freq;
	logic [1:0] ref_source;
	logic aux, doze_active, doze_display;
	logic relay, lmode, tce, sdec;
	int bad_count = 0, n_checks = 0;

	dsr_terminal_model u_dsr_terminal_model (.sys_clk(sys_clk),
		.close_a(close_a), .volt_code(volt_code), .aux_contact_a(aux),
		.voltage_ref_input(vref), .current_ref_input(cref));
	// Short tick keeps hold times and filter steps to a few cycles
	dsr_core #(.TICK_CYCLES(10)) u_dsr_core (.sys_clk(sys_clk),
		.reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .cmd_speed(cmd_speed), .run_active(run_active),
		.start_cmd(start_cmd), .feedback(feedback),
		.voltage_ref_input(vref), .current_ref_input(cref),
		.output_freq(output_freq), .drive_load(drive_load),
		.aux_contact_a(aux), .doze_active(doze_active),
		.doze_display(doze_display), .doze_relay(relay),
		.speed_target(speed_target), .ref_freq(ref_freq),
		.ref_source(ref_source), .local_mode(lmode),
		.terminal_cmd_enable(tce), .setpoint_decrease(sdec),
		.freq_analog_output(fao), .load_analog_output(lao));

	always #20 sys_clk = ~sys_clk;

	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask

	// Request held until pready is sampled high, then released
	// Waits as long as it takes; only the watchdog ends a hung transfer
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge sys_clk);
		penable <= 1;
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0; penable <= 0;
	endtask

	task idle(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	task t_regs;
		apb(0, OFS_REF_HIGH, 0); chk("high point", 32'h258, rd);
		apb(0, OFS_LOAD_SCALE, 0); chk("load scale", 32'h64, rd);
		apb(1, 8'h3c, 32'h1); chk("unmapped err", 1, err);
		apb(0, 8'h3c, 0); chk("unmapped data", 0, rd);
	endtask

	task t_doze;
		apb(1, OFS_LOOP, 500); apb(1, OFS_DOZE_LIMIT, 150);
		apb(1, OFS_DOZE_HOLD, 3); apb(1, OFS_AUX, 32'h100);
		run_active <= 1; cmd_speed <= 100;
		// Hold of 3 ticks needs at least 31 cycles below the limit
		idle(25); chk("hold running", 0, doze_active);
		cmd_speed <= 150; idle(2); cmd_speed <= 100;
		idle(25); chk("hold reload", 0, doze_active);
		for (int i = 0; i < 100 && doze_active !== 1'b1; i++) idle(1);
		chk("doze entry", 1, doze_active);
		idle(2); chk("display", 1, doze_display);
		chk("relay", 1, relay);
		chk("motor zero", 0, speed_target);
		cmd_speed <= 169; idle(40); chk("held", 1, doze_active);
		cmd_speed <= 170; idle(3); chk("wake", 0, doze_active);
		apb(1, OFS_WAKE_BAND, 10); feedback <= 500; cmd_speed <= 100;
		for (int i = 0; i < 100 && doze_active !== 1'b1; i++) idle(1);
		feedback <= 490; idle(30); chk("band edge", 1, doze_active);
		feedback <= 489; idle(2); chk("band wake", 0, doze_active);
		feedback <= 510; apb(1, OFS_LOOP, 32'h101f4);
		for (int i = 0; i < 100 && doze_active !== 1'b1; i++) idle(1);
		idle(30); chk("reverse edge", 1, doze_active);
		feedback <= 511; idle(2); chk("reverse wake", 0, doze_active);
		run_active <= 0; feedback <= 500; idle(3);
		start_cmd <= 1; idle(1); start_cmd <= 0; run_active <= 1;
		idle(3); chk("start bypass", 1, doze_active);
	endtask

	task t_aux;
		apb(1, OFS_PRESET_ONE, 345); apb(1, OFS_AUX, 32'h25);
		close_a <= 1; idle(10);
		chk("decrease", 1, sdec);
		chk("terminal", 1, tce);
		apb(1, OFS_AUX, 32'h24); idle(3);
		chk("local", 1, lmode);
		chk("no terminal", 0, tce);
		apb(1, OFS_AUX, 3); idle(3);
		chk("preset src", 3, ref_source);
		chk("preset freq", 345, ref_freq);
		apb(1, OFS_AUX, 2); idle(3); chk("current src", 2, ref_source);
		apb(1, OFS_AUX, 1); idle(3); chk("voltage src", 1, ref_source);
		close_a <= 0; apb(1, OFS_AUX, 32'h24); idle(10);
		chk("remote", 0, lmode);
		chk("terminal again", 1, tce);
		apb(1, OFS_AUX, 1);
	endtask

	task t_ref(input logic [15:0] lo, hi, input logic [11:0] c,
		input logic [15:0] e);
		apb(1, OFS_REF_LOW, lo); apb(1, OFS_REF_HIGH, hi); volt_code <= c;
		for (int i = 0; i < 600 && ref_freq !== e; i++) idle(1);
		chk("ref freq", e, ref_freq);
	endtask

	task t_mon(input logic [7:0] a, input logic [31:0] d,
		input logic [15:0] f, l, input logic [11:0] ef, el);
		apb(1, a, d); output_freq <= f; drive_load <= l; idle(80);
		chk("freq monitor", ef, fao);
		chk("load monitor", el, lao);
	endtask

	task close_out;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial begin
		#2_000_000;
		bad_count++;
		close_out();
	end

	initial begin
		idle(8);
		reset_n <= 1;
		t_regs();
		t_doze();
		t_aux();
		t_ref(100, 600, 12'h000, 100);
		t_ref(100, 600, 12'hfff, 600);
		t_ref(600, 0, 12'hfff, 0);
		t_ref(600, 0, 12'h000, 600);
		// Heaviest smoothing still far from the new level after 2-3 ticks
		apb(1, OFS_SMOOTH, 7); volt_code <= 12'hfff; idle(25);
		chk("smoothing lag", 1, ref_freq > 16'd300);
		apb(1, OFS_SMOOTH, 0);
		t_ref(0, 600, 12'h800, 300);
		t_mon(OFS_FMON, 32'h10258, 600, 0, 12'hfff, 12'h000);
		t_mon(OFS_LMON, 32'h200c8, 1200, 0, 12'hfff, 12'h333);
		t_mon(OFS_LMON, 32'h100c8, 1200, 200, 12'hfff, 12'hfff);
		t_mon(OFS_FMON, 32'h00258, 600, 200, 12'h000, 12'hfff);
		t_mon(OFS_FMON, 32'h10258, 300, 100, 12'h7ff, 12'h7ff);
		t_mon(OFS_LMON, 32'h200c8, 300, 100, 12'h7ff, 12'h998);
		close_out();
	end
endmodule
